// >>> logic/adcc_top.sv
// conversion control block: axi4-lite slave, control registers,
// conversion sequencer and result registers.
// assumes the analog front end delivers its ten-bit code on sar_code,
// asynchronous to mclk and stable by the end of each conversion time.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
module adcc_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             standby_req,
    input  wire logic [9:0]       sar_code,
    output adcc_pkg::adcc_ana_t   ana_ctrl,
    output logic                  conv_complete_irq
);
    import adcc_pkg::*;

    // elaboration-time check of the address width
    if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_addr
        $error("adcc_top: ADDR_W must lie in 7..32");
    end

    adcc_ctrl1_t       ctrl_one_r;
    adcc_ctrl2_t       ctrl_two_r;
    adcc_state_t       state_r;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  tgt_r;
    logic [9:0]        result_r;
    logic              conv_done_flag_r;
    logic [9:0]        sar_s1_r;
    logic [9:0]        sar_s2_r;
    logic              irq_r;
    adcc_ana_t         ana_r;
    logic              aw_got_r;
    logic              w_got_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [7:0]        wbyte_r;
    logic              wlane_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;

    // address decode: bit 2 is hit, bits 1:0 select the register
    function automatic logic [2:0] reg_dec(input logic [ADDR_W-1:0] a);
        logic [31:0] w;
        w = 32'(a) >> 2;
        reg_dec = {(w >= 32'(IDX_CTRL_ONE)) && (w <= 32'(IDX_RES_HIGH)),
                   w[1:0]};
    endfunction

    // conversion length for a time code; reserved codes take the longest
    function automatic logic [CNT_W-1:0] conv_cycles(input logic [2:0] c);
        case (c)
            ACK_39:   conv_cycles = CYC_39;
            ACK_78:   conv_cycles = CYC_78;
            ACK_156:  conv_cycles = CYC_156;
            ACK_312:  conv_cycles = CYC_312;
            ACK_624:  conv_cycles = CYC_624;
            ACK_1248: conv_cycles = CYC_1248;
            default:  conv_cycles = CYC_1248;
        endcase
    endfunction

    // bus-side strobes
    logic [2:0] wr_dec;
    logic [2:0] rd_dec;
    logic       wr_fire;
    logic       rd_fire;
    logic       wr_one;
    logic       wr_two;
    logic       rd_high;
    assign wr_dec  = reg_dec(awaddr_r);
    assign rd_dec  = reg_dec(s_axi_araddr);
    assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
    assign rd_fire = s_axi_arvalid && !rvalid_r;
    assign wr_one  = wr_fire && wlane_r && wr_dec[2]
                     && (wr_dec[1:0] == SEL_CTRL_ONE) && !standby_req;
    assign wr_two  = wr_fire && wlane_r && wr_dec[2]
                     && (wr_dec[1:0] == SEL_CTRL_TWO) && !standby_req;
    assign rd_high = rd_fire && rd_dec[2] && (rd_dec[1:0] == SEL_RES_HIGH);

    // sequencer events
    logic mode_run;
    logic begin_conv;
    logic comp;
    logic halt;
    assign mode_run   = (ctrl_one_r.mode == MODE_SINGLE)
                        || (ctrl_one_r.mode == MODE_REPEAT);
    assign begin_conv = ctrl_one_r.start && mode_run
                        && (state_r == ST_IDLE) && !standby_req; // see R21
    assign halt       = (state_r == ST_CONV)
                        && (ctrl_one_r.mode == MODE_OFF);        // see R18
    assign comp       = (state_r == ST_CONV) && !halt && !standby_req
                        && (cnt_r == tgt_r - 1'b1);              // see R21

    // handshake outputs
    assign s_axi_awready = !aw_got_r;
    assign s_axi_wready  = !w_got_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign ana_ctrl          = ana_r;
    assign conv_complete_irq = irq_r;

    // write address and data capture, either order
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= '0;
            wbyte_r  <= 8'h00;
            wlane_r  <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_got_r) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got_r <= 1'b0;
            end
            if (s_axi_wvalid && !w_got_r) begin
                w_got_r <= 1'b1;
                wbyte_r <= s_axi_wdata[7:0];
                wlane_r <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_got_r <= 1'b0;
            end
        end
    end

    // write response
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_dec[2] ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // read data path; unused and unstable bits read zero
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_dec[2] ? RESP_OKAY : RESP_SLVERR;
            rdata_r  <= 32'h0000_0000;
            if (rd_dec[2]) begin
                case (rd_dec[1:0])
                    SEL_CTRL_ONE: rdata_r[7:0] <= ctrl_one_r;
                    SEL_CTRL_TWO: rdata_r[5:0] <= ctrl_two_r[5:0]; // see R9
                    SEL_RES_LOW:  rdata_r[7:0] <= {result_r[1:0],
                                                   conv_done_flag_r,
                                                   state_r == ST_CONV,
                                                   4'h0}; // see R15, R22
                    default:      rdata_r[7:0] <= result_r[9:2]; // see R22
                endcase
            end
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // control one: standby reinitialises, start clears itself
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_one_r <= CTRL_ONE_RST;
        end else if (standby_req) begin
            ctrl_one_r <= CTRL_ONE_RST; // see R7
        end else if (wr_one) begin
            ctrl_one_r <= wbyte_r; // see R2, R3, R4
            if (!wbyte_r[7]) begin
                ctrl_one_r.start <= ctrl_one_r.start; // see R1
            end
        end else begin
            ctrl_one_r.start <= 1'b0; // see R1
        end
    end

    // control two: conversion time and ladder control
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_two_r <= CTRL_TWO_RST;
        end else if (standby_req) begin
            ctrl_two_r <= CTRL_TWO_RST; // see R7
        end else if (wr_two) begin
            ctrl_two_r <= {2'h0, wbyte_r[5:0]};
        end
    end

    // sequencer state and cycle counter
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
            tgt_r   <= CYC_39;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (begin_conv) begin
                        state_r <= ST_CONV; // see R14, R16
                        cnt_r   <= '0;
                        tgt_r   <= conv_cycles(ctrl_two_r.ack); // see R11
                    end
                end
                ST_CONV: begin
                    if (standby_req || halt) begin
                        state_r <= ST_IDLE; // see R18, R20, R14
                    end else if (comp) begin
                        cnt_r <= '0;
                        tgt_r <= conv_cycles(ctrl_two_r.ack);
                        if (ctrl_one_r.mode != MODE_REPEAT) begin
                            state_r <= ST_IDLE; // see R16
                        end // else restart at once, see R17
                    end else begin
                        cnt_r <= cnt_r + 1'b1; // see R21
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // analog code synchroniser
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sar_s1_r <= 10'h000;
            sar_s2_r <= 10'h000;
        end else begin
            sar_s1_r <= sar_code;
            sar_s2_r <= sar_s1_r;
        end
    end

    // result store, done flag and completion pulse
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            result_r         <= 10'h000;
            conv_done_flag_r <= 1'b0;
            irq_r            <= 1'b0;
        end else begin
            irq_r <= comp; // see R12
            if (standby_req) begin
                result_r         <= 10'h000; // see R20
                conv_done_flag_r <= 1'b0;
            end else if (comp) begin
                result_r         <= sar_s2_r; // see R12
                conv_done_flag_r <= 1'b1;     // set wins over clear
            end else if (rd_high || begin_conv) begin
                conv_done_flag_r <= 1'b0; // see R13, R19
            end
        end
    end

    // registered analog-side controls
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ana_r <= '0;
        end else begin
            ana_r.chan       <= ctrl_one_r.chan[2:0];  // see R3
            ana_r.chan_ok    <= !ctrl_one_r.chan[3];   // see R3
            ana_r.input_en   <= !ctrl_one_r.gate;      // see R4
            ana_r.ladder_on  <= ctrl_two_r.ladder
                                || (state_r == ST_CONV); // see R10
            ana_r.converting <= (state_r == ST_CONV);
        end
    end

    // checks, all on mclk and masked while reset is high
    default clocking cb_chk @(posedge mclk); endclocking
    default disable iff (sys_rst);

    AST_START_CLEARS: assert property ( // see R1
        ctrl_one_r.start && !wr_one |=> !ctrl_one_r.start)
        else $error("start bit did not clear itself");

    AST_START_BUSY: assert property ( // see R14
        begin_conv |=> state_r == ST_CONV && !conv_done_flag_r)
        else $error("start did not raise busy");

    AST_OFF_IGNORES: assert property ( // see R2
        state_r == ST_IDLE && ctrl_one_r.mode == MODE_OFF
        |=> state_r == ST_IDLE)
        else $error("conversion began in disabled mode");

    AST_HALT_NOW: assert property ( // see R18
        halt |=> state_r == ST_IDLE && $stable(result_r) && !irq_r)
        else $error("halt did not discard conversion");

    // a 39-cycle run still going 38 cycles after it began must complete there
    AST_LENGTH: assert property ( // see R11
        $rose(state_r == ST_CONV) && tgt_r == CYC_39
        |-> ##38 (comp || state_r != ST_CONV))
        else $error("39-cycle conversion ended at wrong time");

    AST_COUNT_BOUND: assert property ( // see R21
        state_r == ST_CONV |-> cnt_r < tgt_r)
        else $error("counter passed conversion time");

    AST_COMPLETE_SET: assert property ( // see R12
        irq_r |-> conv_done_flag_r && result_r == $past(sar_s2_r))
        else $error("completion did not store and flag together");

    AST_RESULT_HOLD: assert property ( // see R19
        !comp && !standby_req |=> $stable(result_r))
        else $error("result changed without completion");

    AST_HIGH_CLEARS: assert property ( // see R13
        rd_high && !comp |=> !conv_done_flag_r)
        else $error("upper result read left done set");

    AST_STANDBY: assert property ( // see R7
        standby_req |=> ctrl_one_r == CTRL_ONE_RST && ctrl_two_r ==
        CTRL_TWO_RST && state_r == ST_IDLE && result_r == 10'h000)
        else $error("standby did not reinitialise");

    AST_REPEAT: assert property ( // see R17
        comp && ctrl_one_r.mode == MODE_REPEAT |=> state_r == ST_CONV
        && cnt_r == '0)
        else $error("repeat mode did not restart");

    AST_SINGLE: assert property ( // see R16
        comp && ctrl_one_r.mode == MODE_SINGLE |=> state_r == ST_IDLE)
        else $error("single mode ran twice");

    AST_LADDER: assert property ( // see R10
        state_r == ST_CONV |=> ana_r.ladder_on)
        else $error("ladder off during conversion");

    AST_GATE: assert property ( // see R4
        ##1 ana_r.input_en == !$past(ctrl_one_r.gate))
        else $error("input gate wrong");

    AST_RD_ZERO: assert property ( // see R15, R22
        rd_fire && rd_dec[2] && rd_dec[1:0] == SEL_RES_LOW
        |=> rdata_r[3:0] == 4'h0 && rdata_r[7:6] == $past(result_r[1:0]))
        else $error("lower result layout wrong");

    COV_SINGLE: cover property (comp && ctrl_one_r.mode == MODE_SINGLE);
    COV_REPEAT: cover property (comp && ctrl_one_r.mode == MODE_REPEAT);
    COV_HALT: cover property (halt);
    COV_STANDBY: cover property (standby_req && state_r == ST_CONV);

endmodule // adcc_top

// >>> logic/adcc_pkg.sv
// conversion control package: register indices, field layouts, reset
// values, mode codes and conversion-time counts.
// assumes a 32-bit axi4-lite register bus; byte address = index * 4.
// Operation
// R1: start bit one begins conversion and clears itself; zero has no effect.
// R2: mode field 00 disable, 01 single software start, 11 repeat, 10 reserved.
// R3: channel codes 0000 to 0111 pick inputs zero to seven; others reserved.
// R4: input-control bit zero enables analog inputs, one disables them.
// R5: software changes channel only while the busy flag reads zero.
// R6: no restart while converting; software awaits done flag or interrupt.
// R7: standby resets control registers; writes ignored until normal mode.
// R8: software writes zero to bit 0 and one to bit 4 of control two.
// R9: control two bits seven and six read as undefined, here zero.
// R10: ladder bit zero: ladder on only while converting; one: always on.
// R11: codes give 39, 78, 156, 312, 624, 1248 clocks; 001, 111 reserved.
// R12: completion stores result, sets done flag and raises interrupt together.
// R13: reading the upper result clears done; read lower register first.
// R14: busy rises at start, falls at finish, and clears on standby entry.
// R15: lower result bits three to zero read unstable, here zero.
// R16: single mode converts the selected channel once per start.
// R17: repeat mode restarts immediately after each completed conversion.
// R18: writing mode 00 halts at once and discards the partial result.
// R19: new start clears done but keeps old result until next completion.
// R20: standby aborts conversion, clears results, no automatic resume.
// R21: sequencer counts to selected time; starts ignored while disabled.
// R22: upper holds result bits 9..2; lower bits 7, 6 hold result bits 1, 0.
package adcc_pkg;

    // register indices; the byte address is four times the index
    localparam logic [7:0] IDX_CTRL_ONE = 8'h1c;
    localparam logic [7:0] IDX_CTRL_TWO = 8'h1d;
    localparam logic [7:0] IDX_RES_LOW  = 8'h1e;
    localparam logic [7:0] IDX_RES_HIGH = 8'h1f;
    localparam logic [1:0] SEL_CTRL_ONE = 2'h0;
    localparam logic [1:0] SEL_CTRL_TWO = 2'h1;
    localparam logic [1:0] SEL_RES_LOW  = 2'h2;
    localparam logic [1:0] SEL_RES_HIGH = 2'h3;

    // reset values
    localparam logic [7:0] CTRL_ONE_RST = 8'h10;
    localparam logic [7:0] CTRL_TWO_RST = 8'h10;

    // operating mode codes
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_RSV    = 2'h2;
    localparam logic [1:0] MODE_REPEAT = 2'h3;

    // conversion-time codes and counts in mclk cycles
    localparam logic [2:0]  ACK_39   = 3'h0;
    localparam logic [2:0]  ACK_78   = 3'h2;
    localparam logic [2:0]  ACK_156  = 3'h3;
    localparam logic [2:0]  ACK_312  = 3'h4;
    localparam logic [2:0]  ACK_624  = 3'h5;
    localparam logic [2:0]  ACK_1248 = 3'h6;
    localparam int          CNT_W    = 11;
    localparam logic [10:0] CYC_39   = 11'h027;
    localparam logic [10:0] CYC_78   = 11'h04e;
    localparam logic [10:0] CYC_156  = 11'h09c;
    localparam logic [10:0] CYC_312  = 11'h138;
    localparam logic [10:0] CYC_624  = 11'h270;
    localparam logic [10:0] CYC_1248 = 11'h4e0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       start;
        logic [1:0] mode;
        logic       gate;     // one disables analog inputs
        logic [3:0] chan;
    } adcc_ctrl1_t;

    typedef struct packed {
        logic [1:0] unused;
        logic       ladder;
        logic       fixed1;
        logic [2:0] ack;
        logic       fixed0;
    } adcc_ctrl2_t;

    typedef struct packed {
        logic [2:0] chan;       // selected analog input
        logic       chan_ok;    // channel code not reserved
        logic       input_en;   // analog inputs enabled
        logic       ladder_on;  // reference ladder connected
        logic       converting; // sample-hold and comparator running
    } adcc_ana_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } adcc_state_t;

endpackage

// >>> tb/adcc_afe_model.sv
// analog front end stand-in: sample-hold and comparator behind the block.
// assumes ana_ctrl from the conversion control block on the same clock.
`timescale 1ns/100ps
module adcc_afe_model (
    input  wire logic                mclk,
    input  wire adcc_pkg::adcc_ana_t ana,
    input  wire logic [9:0]          code_in,
    output logic [9:0]               sar_code
);
    import adcc_pkg::*;

    // start from a known pattern
    initial sar_code = 10'h2aa;

    // code only while converting an enabled, legal input; else it churns
    always @(posedge mclk) begin
        if (ana.converting && ana.input_en && ana.chan_ok) begin
            sar_code <= code_in;
        end else begin
            sar_code <= ~sar_code; // nothing settled on the comparator
        end
    end
endmodule // adcc_afe_model

// >>> tb/testbench.sv
// bench for the conversion control block: registers, single and repeat
// conversions, mode stop, restart, standby and refused starts.
// assumes adcc_top with default ADDR_W and the front-end model beside it.
`timescale 1ns/100ps
module testbench;
    import adcc_pkg::*;
    logic        mclk, irq, awready, wready, bvalid, arready, rvalid;
    logic        sys_rst = 1'b1, standby_req = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, seed = 32'hd713, cyc = 32'h0;
    logic [31:0] irq_n = 32'h0, irq_at, wcyc, rdv, k, a, rdata_w;
    logic [1:0]  bresp, rresp, r;
    logic [9:0]  code_in = 10'h0, sar_code, c1;
    adcc_ana_t   ana;
    int          error_cnt = 0, checks_done = 0;

    adcc_top u_adcc_top (
        .mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata_w), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .standby_req(standby_req),
        .sar_code(sar_code), .ana_ctrl(ana), .conv_complete_irq(irq));
    adcc_afe_model u_adcc_afe_model (.mclk(mclk), .ana(ana),
        .code_in(code_in), .sar_code(sar_code));

    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // cycle count and completion pulse log
    always @(posedge mclk) begin
        cyc <= cyc + 32'h1;
        if (irq === 1'b1) begin
            irq_n  <= irq_n + 32'h1;
            irq_at <= cyc;
        end
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic tmo();
        error_cnt++;
        $display("wait limit reached at %0t", $time);
        give_verdict();
    endtask

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic note(input string s);
        $display("test %s done, %0d checks, %0d wrong", s, checks_done,
                 error_cnt);
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // expected conversion length per time code
    function automatic logic [10:0] tcyc(input logic [2:0] c);
        case (c)
            ACK_39:  return CYC_39;
            ACK_78:  return CYC_78;
            ACK_156: return CYC_156;
            ACK_312: return CYC_312;
            ACK_624: return CYC_624;
            default: return CYC_1248;
        endcase
    endfunction

    // one register write; address and data held until each is taken
    task automatic wr(input logic [7:0] ad, input logic [7:0] dv);
        int n;
        n = 0;
        awaddr  <= ad;
        wdata   <= {24'h0, dv};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        r    = bresp;
        wcyc = cyc;
        if (n >= 50) tmo();
    endtask

    // one register read
    task automatic rd(input logic [7:0] ad);
        int n;
        n = 0;
        araddr  <= ad;
        arvalid <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        rdv = rdata_w;
        r   = rresp;
        if (n >= 50) tmo();
    endtask

    task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
        rd(ad);
        chk_data(rdv, {24'h0, e});
        chk_resp(r, RESP_OKAY);
    endtask

    task automatic wait_irq(input logic [31:0] t);
        int n;
        n = 0;
        while (irq_n < t && n < 1400) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 1400) tmo();
    endtask

    // single conversion with time code c, random channel and code
    task automatic conv_once(input logic [2:0] c);
        logic [2:0] ch;
        seed = lfsr(seed);
        ch = seed[12:10];
        c1 = code_in; // previous result stays until this one completes
        code_in <= seed[9:0];
        wr(8'h74, {4'h1, c, 1'b0});
        wr(8'h70, {5'h04, ch});
        @(posedge mclk);
        chk_data({25'h0, ana}, {25'h0, ch, 4'b1100});
        k = irq_n;
        wr(8'h70, {5'h14, ch});
        a = wcyc;
        rchk(8'h78, {c1[1:0], 6'h10});
        chk_data({25'h0, ana}, {25'h0, ch, 4'b1111});
        rchk(8'h70, {5'h04, ch});
        wait_irq(k + 32'h1);
        chk_data(irq_at - a, {21'h0, tcyc(c)} + 32'h1);
        rchk(8'h78, {code_in[1:0], 6'h20});
        rchk(8'h7c, code_in[9:2]);
        rchk(8'h78, {code_in[1:0], 6'h00});
        chk_data(irq_n, k + 32'h1);
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rchk(8'h70, 8'h10);
        rchk(8'h74, 8'h10);
        rchk(8'h7c, 8'h00);
        wr(8'h74, 8'hd8);
        rchk(8'h74, 8'h18);
        rchk(8'h78, 8'h00);
        wr(8'h40, 8'h01);
        chk_resp(r, RESP_SLVERR);
        rd(8'h40);
        chk_resp(r, RESP_SLVERR);
        note("registers");
        for (int c = 0; c < 8; c++) conv_once(c[2:0]);
        note("single");
        // reserved channel, then repeat mode with a stop in mid-run
        wr(8'h70, 8'h28);
        @(posedge mclk);
        chk_data({25'h0, ana}, 32'h04);
        wr(8'h74, 8'h30);
        wr(8'h70, 8'h60);
        @(posedge mclk);
        chk_data({25'h0, ana}, 32'h0e);
        k = irq_n;
        wr(8'h70, 8'he0);
        wait_irq(k + 32'h1);
        a = irq_at;
        seed = lfsr(seed);
        code_in <= seed[9:0];
        wait_irq(k + 32'h2);
        chk_data(irq_at - a, 32'd39);
        rchk(8'h7c, code_in[9:2]);
        c1 = code_in;
        code_in <= ~c1;
        wr(8'h70, 8'h00);
        repeat (60) @(posedge mclk);
        chk_data(irq_n, k + 32'h2);
        rchk(8'h78, {c1[1:0], 6'h00});
        rchk(8'h7c, c1[9:2]);
        note("repeat");
        // restart before the result is read
        wr(8'h70, 8'h20);
        k = irq_n;
        wr(8'h70, 8'ha0);
        wait_irq(k + 32'h1);
        c1 = code_in;
        code_in <= ~c1;
        wr(8'h70, 8'ha0);
        rchk(8'h78, {c1[1:0], 6'h10});
        rchk(8'h7c, c1[9:2]);
        wait_irq(k + 32'h2);
        rchk(8'h7c, ~c1[9:2]);
        note("restart");
        // standby entry mid-conversion
        k = irq_n;
        wr(8'h70, 8'ha0);
        repeat (5) @(posedge mclk);
        standby_req <= 1'b1;
        repeat (2) @(posedge mclk);
        wr(8'h70, 8'h25);
        rchk(8'h70, 8'h10);
        rchk(8'h74, 8'h10);
        rchk(8'h78, 8'h00);
        rchk(8'h7c, 8'h00);
        standby_req <= 1'b0;
        repeat (60) @(posedge mclk);
        chk_data(irq_n, k);
        note("standby");
        // starts in the disabled and reserved modes are ignored
        for (int m = 0; m < 2; m++) begin
            wr(8'h70, (m == 0) ? 8'h80 : 8'hc0);
            repeat (60) @(posedge mclk);
            chk_data(irq_n, k);
            rchk(8'h78, 8'h00);
        end
        note("refused");
        give_verdict();
    end
endmodule // testbench
